// ---- rtl/clock_gen_ctrl_map.vh ----
// Register offsets, field positions and reset values of the upper control bytes
`ifndef CLOCK_GEN_CTRL_MAP_VH
`define CLOCK_GEN_CTRL_MAP_VH

// Command codes (byte offsets) of the registers
`define OFS_CPU_POWERDOWN_DRIVE_CFG 3'h4
`define OFS_REF_PAIR_DRIVE_CFG      3'h5
`define OFS_TEST_AND_STOP_CTRL      3'h6
`define OFS_IDENTITY_READBACK       3'h7

// Writable bit masks; every other bit is reserved or read-only
`define MASK_CPU_POWERDOWN_DRIVE    8'hf0
`define MASK_REF_PAIR_DRIVE         8'h60
`define MASK_TEST_AND_STOP          8'hd8

// Reset values
`define RST_CPU_POWERDOWN_DRIVE     8'h00
`define RST_REF_PAIR_DRIVE          8'h00
`define RST_TEST_AND_STOP           8'h18

// Field positions
`define BIT_CPU_PD_LSB              4
`define BIT_SRC_STOP_TRISTATE       6
`define BIT_SRC_PD_TRISTATE         5
`define BIT_TEST_SEL                7
`define BIT_TEST_MODE               6
`define BIT_REF_DRIVE_HIGH          4
`define BIT_SW_STOP_DEASSERT        3

// Command code bit that picks byte (1) or block (0) transfers
`define BIT_CMD_BYTE_MODE           7
// Byte count returned first in a block read
`define BLOCK_READ_COUNT            8'h08

`endif

// ---- rtl/clock_gen_ctrl_regs_hi.v ----
// Upper control, stop and readback registers with their SMBus slave port
// What this block does
// (RULE_01) CPU PD drive bits 7:4: driven or tri-state
// (RULE_02) Reference stop drive bit 6: driven or tri-state
// (RULE_03) Reference power-down drive bit 5
// (RULE_04) Test mode enable bit 6, resets 0
// (RULE_05) Test select bit 7: tri-state or divided clock
// (RULE_06) Reference drive strength bit 4, resets high
// (RULE_07) Stop bit 0 halts stoppable outputs cleanly
// (RULE_08) Stop bit 1 resumes outputs; resets to 1
// (RULE_09) Bits 2:0 read latched select pins C,B,A
// (RULE_10) Select readback is 0 if pin low
// (RULE_11) Identity byte: revision high, vendor low, read-only
// (RULE_12) Drive bit 0: true high, complement off
// (RULE_13) Only stoppable-selected outputs obey the stop
// (RULE_14) SMBus byte/block access by command code, acked
// (RULE_15) Host writes zero to reserved bits
// (RULE_16) Reserved bits read 0; read-only writes ignored
`timescale 1ns/100ps
`include "clock_gen_ctrl_map.vh"
module clock_gen_ctrl_regs_hi
#(
   parameter [6:0] SLAVE_ADDR  = 7'h69, // Bus address of the device
   parameter [3:0] REV_CODE    = 4'h3,  // Arbitrary value
   parameter [3:0] VENDOR_CODE = 4'h6   // Arbitrary value
)
(
   input  wire       clock_i,                   // System clock
   input  wire       rst_n_i,                   // Asynchronous reset, active low
   input  wire       smb_clk_i,                 // SMBus clock level
   input  wire       smb_data_i,                // SMBus data level
   output reg        smb_data_o,                // SMBus data out, always low
   output reg        smb_data_oe_n_o,           // Low while pulling data low
   input  wire       freq_select_a_i,           // Frequency select pin A
   input  wire       freq_select_b_i,           // Frequency select pin B
   input  wire       freq_select_c_i,           // Frequency select pin C
   input  wire       power_good_latch_n_i,      // Power good, active low
   input  wire       power_down_input_i,        // Power-down request, high
   input  wire       clk_low_phase_i,           // Output clocks are low now
   input  wire [4:0] src_stop_sel_i,            // Stoppable select per ref pair
   input  wire [2:0] free_run_periph_stop_sel_i,// Stoppable select per free clock
   output reg  [3:0] cpu_true_hold_o,           // CPU true pin held high
   output reg  [3:0] cpu_pair_tristate_o,       // CPU pair fully tri-state
   output reg  [4:0] serial_ref_diff_pair_hold_o,     // Ref true pin held high
   output reg  [4:0] serial_ref_diff_pair_tristate_o, // Ref pair tri-state
   output reg  [4:0] serial_ref_diff_pair_halt_o,     // Ref pair halted by stop
   output reg  [2:0] free_run_periph_clock_halt_o,    // Free clock halted
   output reg        periph_halt_o,             // Stoppable peripheral clocks halted
   output reg        test_tristate_o,           // Test mode: all outputs off
   output reg        test_ref_div_o,            // Test mode: divided reference out
   output reg        ref_drive_high_o,          // Reference drive strength high
   output reg        freq_select_valid_o        // Select pins have been latched
);

   // Bus states, one-hot
   localparam [6:0] ST_IDLE  = 7'h01; // Waiting for a start
   localparam [6:0] ST_ADDR  = 7'h02; // Receiving slave address
   localparam [6:0] ST_CMD   = 7'h04; // Receiving command code
   localparam [6:0] ST_WCNT  = 7'h08; // Receiving block byte count
   localparam [6:0] ST_WDATA = 7'h10; // Receiving data bytes
   localparam [6:0] ST_RDATA = 7'h20; // Sending data bytes
   localparam [6:0] ST_SKIP  = 7'h40; // Not addressed or read ended by NACK, wait for stop

   reg  [7:0] cpu_powerdown_drive_cfg; // Writable bits of the CPU byte
   reg  [7:0] ref_pair_drive_cfg;      // Writable bits of the reference byte
   reg  [7:0] test_and_stop_ctrl;      // Writable bits of the test/stop byte
   reg  [2:0] freq_select;             // Latched select pins C,B,A
   reg        freq_latched;            // Select pins captured
   reg        stop_active;             // Stop applied at a clean boundary
   reg        scl_q;                   // Previous bus clock
   reg        sda_q;                   // Previous bus data
   reg  [6:0] state;                   // Bus state
   reg  [3:0] bitcnt;                  // Bit position within a byte
   reg  [7:0] shreg;                   // Receive shift register
   reg  [7:0] txreg;                   // Transmit shift register
   reg        acking;                  // Slave ack slot in progress
   reg  [2:0] ptr;                     // Register pointer
   reg        unmapped;                // Command code outside this bank, or pointer past the last register
   reg        byte_mode;               // Single byte transfer
   reg        drive_ack;               // Ack will be driven in this slot

   wire scl_rise  = smb_clk_i & ~scl_q;
   wire scl_fall  = ~smb_clk_i & scl_q;
   wire bus_start = smb_clk_i & scl_q & sda_q & ~smb_data_i;
   wire bus_stop  = smb_clk_i & scl_q & ~sda_q & smb_data_i;
   wire in_pd     = freq_latched & power_down_input_i;

   // Read value of one register; reserved and unmapped bits are zero
   function [7:0] reg_read;
      input [2:0] idx;
      input       off;
      begin
         reg_read = 8'h00;
         if (!off)
         begin
            case (idx)
               `OFS_CPU_POWERDOWN_DRIVE_CFG: reg_read = cpu_powerdown_drive_cfg;
               `OFS_REF_PAIR_DRIVE_CFG:      reg_read = ref_pair_drive_cfg;
               `OFS_TEST_AND_STOP_CTRL:      reg_read = test_and_stop_ctrl |
                                                        {5'h00, freq_select}; // RULE_09
               `OFS_IDENTITY_READBACK:       reg_read = {REV_CODE, VENDOR_CODE}; // RULE_11
               default:                      reg_read = 8'h00;
            endcase
         end
      end
   endfunction

   // Register byte at the pointer, and the first byte of a read
   wire [7:0] read_now = reg_read(ptr, unmapped);
   wire [7:0] first_tx = byte_mode ? read_now : `BLOCK_READ_COUNT;

   // Capture select pins once power good goes low
   always @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         freq_select  <= 3'h0;
         freq_latched <= 1'b0;
      end
      else if (!freq_latched && !power_good_latch_n_i)
      begin
         freq_select  <= {freq_select_c_i, freq_select_b_i, freq_select_a_i}; // RULE_09 RULE_10
         freq_latched <= 1'b1;
      end
   end

   // Software stop only changes while clocks are low, so no short pulse
   always @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         stop_active <= 1'b0;
      else if (clk_low_phase_i)
         stop_active <= ~test_and_stop_ctrl[`BIT_SW_STOP_DEASSERT]; // RULE_07 RULE_08
   end

   // Output decode, all registered
   always @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cpu_true_hold_o                 <= 4'h0;
         cpu_pair_tristate_o             <= 4'h0;
         serial_ref_diff_pair_hold_o     <= 5'h00;
         serial_ref_diff_pair_tristate_o <= 5'h00;
         serial_ref_diff_pair_halt_o     <= 5'h00;
         free_run_periph_clock_halt_o    <= 3'h0;
         periph_halt_o                   <= 1'b0;
         test_tristate_o                 <= 1'b0;
         test_ref_div_o                  <= 1'b0;
         ref_drive_high_o                <= 1'b1;
         freq_select_valid_o             <= 1'b0;
      end
      else
      begin
         // Power-down: bit 0 holds true high, bit 1 floats the pair
         cpu_true_hold_o <= {4{in_pd}} &
            ~cpu_powerdown_drive_cfg[`BIT_CPU_PD_LSB+3:`BIT_CPU_PD_LSB]; // RULE_01 RULE_12
         cpu_pair_tristate_o <= {4{in_pd}} &
            cpu_powerdown_drive_cfg[`BIT_CPU_PD_LSB+3:`BIT_CPU_PD_LSB]; // RULE_01 RULE_12
         // Reference pairs: power-down covers all five, stop only selected ones
         serial_ref_diff_pair_hold_o <=
            ({5{in_pd & ~ref_pair_drive_cfg[`BIT_SRC_PD_TRISTATE]}}) |
            ({5{~in_pd & stop_active & ~ref_pair_drive_cfg[`BIT_SRC_STOP_TRISTATE]}} &
             src_stop_sel_i); // RULE_02 RULE_03 RULE_12
         serial_ref_diff_pair_tristate_o <=
            ({5{in_pd & ref_pair_drive_cfg[`BIT_SRC_PD_TRISTATE]}}) |
            ({5{~in_pd & stop_active & ref_pair_drive_cfg[`BIT_SRC_STOP_TRISTATE]}} &
             src_stop_sel_i); // RULE_02 RULE_03
         serial_ref_diff_pair_halt_o  <= {5{stop_active}} & src_stop_sel_i; // RULE_13
         free_run_periph_clock_halt_o <= {3{stop_active}} &
                                         free_run_periph_stop_sel_i; // RULE_13
         periph_halt_o <= stop_active; // RULE_07
         // Test clock mode
         test_tristate_o <= test_and_stop_ctrl[`BIT_TEST_MODE] &
                            ~test_and_stop_ctrl[`BIT_TEST_SEL]; // RULE_04 RULE_05
         test_ref_div_o  <= test_and_stop_ctrl[`BIT_TEST_MODE] &
                            test_and_stop_ctrl[`BIT_TEST_SEL]; // RULE_04 RULE_05
         ref_drive_high_o    <= test_and_stop_ctrl[`BIT_REF_DRIVE_HIGH]; // RULE_06
         freq_select_valid_o <= freq_latched;
      end
   end

   // SMBus slave and register writes
   always @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         scl_q                   <= 1'b1;
         sda_q                   <= 1'b1;
         state                   <= ST_IDLE;
         bitcnt                  <= 4'h0;
         shreg                   <= 8'h00;
         txreg                   <= 8'h00;
         acking                  <= 1'b0;
         drive_ack               <= 1'b0;
         ptr                     <= 3'h0;
         unmapped                <= 1'b0;
         byte_mode               <= 1'b0;
         smb_data_o              <= 1'b0;
         smb_data_oe_n_o         <= 1'b1;
         cpu_powerdown_drive_cfg <= `RST_CPU_POWERDOWN_DRIVE;
         ref_pair_drive_cfg      <= `RST_REF_PAIR_DRIVE;
         test_and_stop_ctrl      <= `RST_TEST_AND_STOP; // RULE_04 RULE_06 RULE_08
      end
      else
      begin
         scl_q <= smb_clk_i;
         sda_q <= smb_data_i;
         if (bus_start)
         begin
            // Start or repeated start; pointer survives for a read
            state           <= ST_ADDR;
            bitcnt          <= 4'h0;
            acking          <= 1'b0;
            smb_data_oe_n_o <= 1'b1;
         end
         else if (bus_stop)
         begin
            state           <= ST_IDLE;
            acking          <= 1'b0;
            smb_data_oe_n_o <= 1'b1;
         end
         else
         begin
            case (state)
               ST_ADDR, ST_CMD, ST_WCNT, ST_WDATA:
               begin
                  if (scl_rise && !acking && bitcnt < 4'h8)
                  begin
                     shreg  <= {shreg[6:0], smb_data_i};
                     bitcnt <= bitcnt + 4'h1;
                  end
                  else if (scl_fall && bitcnt == 4'h8 && !acking)
                  begin
                     // Byte complete: act on it and open the ack slot
                     acking <= 1'b1;
                     drive_ack <= (state != ST_ADDR) || (shreg[7:1] == SLAVE_ADDR);
                     smb_data_oe_n_o <= ~((state != ST_ADDR) ||
                                          (shreg[7:1] == SLAVE_ADDR)); // RULE_14
                     if (state == ST_CMD)
                     begin
                        ptr       <= shreg[2:0];
                        unmapped  <= (shreg[6:3] != 4'h0) || (shreg[2] == 1'b0);
                        byte_mode <= shreg[`BIT_CMD_BYTE_MODE]; // RULE_14
                     end
                     else if (state == ST_WDATA)
                     begin
                        // Only writable bits store; others stay zero or read-only
                        if (!unmapped && ptr == `OFS_CPU_POWERDOWN_DRIVE_CFG)
                           cpu_powerdown_drive_cfg <= shreg & `MASK_CPU_POWERDOWN_DRIVE; // RULE_16
                        if (!unmapped && ptr == `OFS_REF_PAIR_DRIVE_CFG)
                           ref_pair_drive_cfg <= shreg & `MASK_REF_PAIR_DRIVE; // RULE_16
                        if (!unmapped && ptr == `OFS_TEST_AND_STOP_CTRL)
                           test_and_stop_ctrl <= shreg & `MASK_TEST_AND_STOP; // RULE_07 RULE_16
                        unmapped <= unmapped | (ptr == 3'h7);
                        ptr      <= ptr + 3'h1;
                     end
                  end
                  else if (scl_fall && acking)
                  begin
                     // Ack slot over: release and pick the next phase
                     acking          <= 1'b0;
                     bitcnt          <= 4'h0;
                     smb_data_oe_n_o <= 1'b1;
                     if (!drive_ack)
                        state <= ST_SKIP;
                     else if (state == ST_ADDR && shreg[0])
                     begin
                        // Read: block reads send the count first
                        state           <= ST_RDATA;
                        txreg           <= first_tx;
                        smb_data_oe_n_o <= first_tx[7];
                     end
                     else if (state == ST_ADDR)
                        state <= ST_CMD;
                     else if (state == ST_CMD)
                        state <= byte_mode ? ST_WDATA : ST_WCNT;
                     else if (state == ST_WCNT)
                        state <= ST_WDATA;
                  end
               end
               ST_RDATA:
               begin
                  if (scl_rise && bitcnt < 4'h8)
                     bitcnt <= bitcnt + 4'h1;
                  else if (scl_rise && bitcnt == 4'h8)
                  begin
                     // Master ack sampled; a NACK ends the read
                     if (smb_data_i)
                        state <= ST_SKIP;
                     else
                        bitcnt <= 4'h9;
                  end
                  else if (scl_fall && bitcnt > 4'h0 && bitcnt < 4'h8)
                  begin
                     txreg           <= {txreg[6:0], 1'b0};
                     smb_data_oe_n_o <= txreg[6];
                  end
                  else if (scl_fall && bitcnt == 4'h8)
                     smb_data_oe_n_o <= 1'b1;
                  else if (scl_fall && bitcnt == 4'h9)
                  begin
                     // Next byte from the pointer, which then advances
                     bitcnt          <= 4'h0;
                     txreg           <= read_now;
                     smb_data_oe_n_o <= read_now[7];
                     unmapped        <= unmapped | (ptr == 3'h7);
                     ptr             <= ptr + 3'h1;
                  end
               end
               ST_IDLE, ST_SKIP:
                  smb_data_oe_n_o <= 1'b1;
               default:
                  state <= ST_IDLE;
            endcase
         end
      end
   end

endmodule

// ---- verif/clock_gen_ctrl_regs_hi_props.sv ----
// Checker of the upper control register outputs
`timescale 1ns/100ps
module clock_gen_ctrl_regs_hi_props
(
   input wire       clock_i,
   input wire       rst_n_i,
   input wire       smb_clk_i,
   input wire       smb_data_o,
   input wire       smb_data_oe_n_o,
   input wire       clk_low_phase_i,
   input wire [4:0] src_stop_sel_i,
   input wire [2:0] free_run_periph_stop_sel_i,
   input wire [3:0] cpu_true_hold_o,
   input wire [3:0] cpu_pair_tristate_o,
   input wire [4:0] serial_ref_diff_pair_hold_o,
   input wire [4:0] serial_ref_diff_pair_tristate_o,
   input wire [4:0] serial_ref_diff_pair_halt_o,
   input wire [2:0] free_run_periph_clock_halt_o,
   input wire       periph_halt_o,
   input wire       test_tristate_o,
   input wire       test_ref_div_o,
   input wire       freq_select_valid_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // A pair is either held or tristated, never both
   AST_CPU_EXCL: assert property ((cpu_true_hold_o & cpu_pair_tristate_o) == 4'h0)
      else $error("cpu hold/tristate overlap");
   // Power-down covers every cpu pair at once
   AST_CPU_ALL: assert property (|(cpu_true_hold_o | cpu_pair_tristate_o) |->
      (cpu_true_hold_o | cpu_pair_tristate_o) == 4'hf) else $error("cpu pairs split");
   // Reference pairs likewise exclusive
   AST_REF_EXCL: assert property (
      (serial_ref_diff_pair_hold_o & serial_ref_diff_pair_tristate_o) == 5'h0)
      else $error("ref hold/tristate overlap");
   // Only selected reference pairs halt
   AST_REF_HALT: assert property (serial_ref_diff_pair_halt_o ==
      ({5{periph_halt_o}} & $past(src_stop_sel_i))) else $error("reference halt ignores select");
   // Only selected free clocks halt
   AST_FREE_HALT: assert property (free_run_periph_clock_halt_o ==
      ({3{periph_halt_o}} & $past(free_run_periph_stop_sel_i))) else $error("free clock halt wrong");
   // Halt moves only in the low phase of the clocks
   AST_STOP_PHASE: assert property (
      $changed(periph_halt_o) |-> $past(clk_low_phase_i, 2)) else $error("halt outside low phase");
   // Both test outputs never together
   AST_TEST_EXCL: assert property (!(test_tristate_o && test_ref_div_o))
      else $error("test outputs overlap");
   // Latched select pins stay latched
   AST_SEL_HOLD: assert property (freq_select_valid_o |=> freq_select_valid_o)
      else $error("select latch lost");
   // Data pin moves only after a clock low sample
   AST_SDA_MOVE: assert property ($changed(smb_data_oe_n_o) |-> !$past(smb_clk_i))
      else $error("data moved, clock high");
   // Open drain output never drives high
   AST_OPEN_DRAIN: assert property (smb_data_o == 1'b0)
      else $error("data output not low");
   COV_HALT: cover property ($rose(periph_halt_o));
   COV_DIV: cover property ($rose(test_ref_div_o));
   COV_CPU_TRI: cover property (|cpu_pair_tristate_o);
   COV_ACK: cover property ($fell(smb_data_oe_n_o));
endmodule
bind clock_gen_ctrl_regs_hi clock_gen_ctrl_regs_hi_props props_i
(
   .clock_i(clock_i), .rst_n_i(rst_n_i), .smb_clk_i(smb_clk_i), .smb_data_o(smb_data_o),
   .smb_data_oe_n_o(smb_data_oe_n_o), .clk_low_phase_i(clk_low_phase_i),
   .src_stop_sel_i(src_stop_sel_i), .free_run_periph_stop_sel_i(free_run_periph_stop_sel_i),
   .cpu_true_hold_o(cpu_true_hold_o), .cpu_pair_tristate_o(cpu_pair_tristate_o),
   .serial_ref_diff_pair_hold_o(serial_ref_diff_pair_hold_o),
   .serial_ref_diff_pair_tristate_o(serial_ref_diff_pair_tristate_o),
   .serial_ref_diff_pair_halt_o(serial_ref_diff_pair_halt_o),
   .free_run_periph_clock_halt_o(free_run_periph_clock_halt_o), .periph_halt_o(periph_halt_o),
   .test_tristate_o(test_tristate_o), .test_ref_div_o(test_ref_div_o),
   .freq_select_valid_o(freq_select_valid_o)
);

// ---- verif/smbus_host_model.sv ----
// Host model driving the two-wire register port
`timescale 1ns/100ps
module smbus_host_model
(
   input  wire clock_i,    // System clock
   input  wire smb_data_i, // Wired data level
   output reg  smb_clk_o,  // Bus clock
   output reg  smb_data_o  // Data drive, 1 = released
);
   // Idle bus, both lines released
   initial
   begin
      smb_clk_o = 1'b1;
      smb_data_o = 1'b1;
   end
   // Start (1,0) or stop (0,1): data edge with clock high
   task cond(input logic first, input logic second);
   begin
      @(posedge clock_i) smb_clk_o <= 1'b0;
      repeat (2) @(posedge clock_i) smb_data_o <= first;
      repeat (2) @(posedge clock_i) smb_clk_o <= 1'b1;
      repeat (4) @(posedge clock_i) smb_data_o <= second;
      repeat (4) @(posedge clock_i);
   end
   endtask
   // One bit: data set while clock low, sampled mid high phase
   task bit_io(input logic b, output logic r);
   begin
      @(posedge clock_i) smb_clk_o <= 1'b0;
      repeat (2) @(posedge clock_i) smb_data_o <= b;
      repeat (2) @(posedge clock_i) smb_clk_o <= 1'b1;
      repeat (2) @(posedge clock_i);
      #1 r = smb_data_i;
      repeat (2) @(posedge clock_i);
   end
   endtask
   // Byte out, most significant bit first, then ack slot
   task send_byte(input logic [7:0] b, output logic ack);
      logic r;
   begin
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], r);
      bit_io(1'b1, ack);
   end
   endtask
   // Byte in, then host ack (0) or not-ack (1)
   task recv_byte(output logic [7:0] b, input logic nack);
      logic r;
   begin
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, b[i]);
      bit_io(nack, r);
   end
   endtask
endmodule

// ---- verif/tb_clock_gen_ctrl_regs_hi.sv ----
// Self-checking bench of the upper control registers
`timescale 1ns/100ps
module tb_clock_gen_ctrl_regs_hi;
   localparam [6:0] ADDR = 7'h69;
   localparam [3:0] REV  = 4'h3; // Arbitrary value
   localparam [3:0] VEN  = 4'h6; // Arbitrary value
   reg        clock_i, rst_n_i, sel_a, sel_b, sel_c, pgood_n, pwr_down, low_phase;
   reg  [4:0] ref_sel;
   reg  [2:0] free_sel;
   wire       scl, host_sda, dut_sda, dut_oe_n, p_halt, t_tri, t_div, ref_high, sel_ok;
   wire [3:0] cpu_hold, cpu_tri;
   wire [4:0] ref_hold, ref_tri, ref_halt;
   wire [2:0] free_halt;
   wire       sda_line = host_sda & (dut_oe_n | dut_sda); // Wired-AND with pull-up
   int        mismatches, check_count;
   smbus_host_model host (.clock_i(clock_i), .smb_data_i(sda_line), .smb_clk_o(scl),
      .smb_data_o(host_sda));
   clock_gen_ctrl_regs_hi #(.SLAVE_ADDR(ADDR), .REV_CODE(REV), .VENDOR_CODE(VEN)) dut
   (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .smb_clk_i(scl), .smb_data_i(sda_line),
      .smb_data_o(dut_sda), .smb_data_oe_n_o(dut_oe_n), .freq_select_a_i(sel_a),
      .freq_select_b_i(sel_b), .freq_select_c_i(sel_c), .power_good_latch_n_i(pgood_n),
      .power_down_input_i(pwr_down), .clk_low_phase_i(low_phase), .src_stop_sel_i(ref_sel),
      .free_run_periph_stop_sel_i(free_sel), .cpu_true_hold_o(cpu_hold),
      .cpu_pair_tristate_o(cpu_tri), .serial_ref_diff_pair_hold_o(ref_hold),
      .serial_ref_diff_pair_tristate_o(ref_tri), .serial_ref_diff_pair_halt_o(ref_halt),
      .free_run_periph_clock_halt_o(free_halt), .periph_halt_o(p_halt),
      .test_tristate_o(t_tri), .test_ref_div_o(t_div), .ref_drive_high_o(ref_high),
      .freq_select_valid_o(sel_ok)
   );
   // Clock at 40 MHz
   initial
   begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   // Low-phase marker of the output clocks
   always @(posedge clock_i)
      low_phase <= ~low_phase;
   // Verdict and end of run
   task print_verdict;
   begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask
   // Compare one value
   task check_val(input logic [7:0] got, input logic [7:0] exp);
   begin
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   // Byte-mode write
   task reg_write(input logic [7:0] cmd, input logic [7:0] val);
      logic a0, a1, a2;
   begin
      host.cond(1'b1, 1'b0);
      host.send_byte({ADDR, 1'b0}, a0);
      host.send_byte(cmd | 8'h80, a1);
      host.send_byte(val, a2);
      host.cond(1'b0, 1'b1);
      check_val({5'h0, a0, a1, a2}, 8'h00);
   end
   endtask
   // Byte-mode read compared with an expectation
   task read_check(input logic [7:0] cmd, input logic [7:0] exp);
      logic a0, a1, a2;
      logic [7:0] v;
   begin
      host.cond(1'b1, 1'b0);
      host.send_byte({ADDR, 1'b0}, a0);
      host.send_byte(cmd | 8'h80, a1);
      host.cond(1'b1, 1'b0);
      host.send_byte({ADDR, 1'b1}, a2);
      host.recv_byte(v, 1'b1);
      host.cond(1'b0, 1'b1);
      check_val({5'h0, a0, a1, a2}, 8'h00);
      check_val(v, exp);
   end
   endtask
   // Block read after reset
   task t_block_read;
      logic a0, a1, a2;
      logic [7:0] v;
      logic [39:0] exp;
   begin
      exp = {8'h08, 8'h00, 8'h00, 8'h1d, REV, VEN};
      host.cond(1'b1, 1'b0);
      host.send_byte({ADDR, 1'b0}, a0);
      host.send_byte(8'h04, a1);
      host.cond(1'b1, 1'b0);
      host.send_byte({ADDR, 1'b1}, a2);
      for (int i = 0; i < 5; i++)
      begin
         host.recv_byte(v, i == 4);
         check_val(v, exp[39 - 8 * i -: 8]);
      end
      host.cond(1'b0, 1'b1);
      check_val({5'h0, a0, a1, a2}, 8'h00);
      check_val({4'h0, sel_ok, ref_high, t_tri, t_div}, 8'h0c);
   end
   endtask
   // All ones into each byte, unmapped one too
   task t_masks;
      logic [39:0] cmds, exps;
   begin
      cmds = 40'h0405060702;
      exps = {8'hf0, 8'h60, 8'hdd, REV, VEN, 8'h00};
      for (int i = 0; i < 5; i++)
      begin
         reg_write(cmds[39 - 8 * i -: 8], 8'hff);
         read_check(cmds[39 - 8 * i -: 8], exps[39 - 8 * i -: 8]);
      end
      reg_write(8'h04, 8'h00);
      reg_write(8'h05, 8'h00);
   end
   endtask
   // Normal, tristate test and divided clock test, drive strength
   task t_test_modes;
      logic [23:0] vals, exps;
   begin
      vals = {8'h18, 8'h58, 8'hc8};
      exps = {8'h04, 8'h06, 8'h01};
      for (int i = 0; i < 3; i++)
      begin
         reg_write(8'h06, vals[23 - 8 * i -: 8]);
         repeat (3) @(posedge clock_i);
         check_val({5'h0, ref_high, t_tri, t_div}, exps[23 - 8 * i -: 8]);
      end
      reg_write(8'h06, 8'h18);
   end
   endtask
   // Software stop on selected outputs, then resume
   task t_stop;
   begin
      ref_sel <= 5'h05;
      free_sel <= 3'h2;
      reg_write(8'h06, 8'h10);
      repeat (4) @(posedge clock_i);
      check_val({p_halt, free_halt, 4'h0}, 8'ha0);
      check_val({3'h0, ref_halt}, 8'h05);
      check_val({3'h0, ref_hold}, 8'h05);
      reg_write(8'h05, 8'h40);
      check_val({3'h0, ref_tri}, 8'h05);
      reg_write(8'h06, 8'h18);
      reg_write(8'h05, 8'h00);
      check_val({p_halt, free_halt, ref_tri[3:0]}, 8'h00);
      check_val({3'h0, ref_halt}, 8'h00);
   end
   endtask
   // Power-down drive modes per pair
   task t_power_down;
   begin
      reg_write(8'h04, 8'ha0);
      reg_write(8'h05, 8'h20);
      pwr_down <= 1'b1;
      repeat (8) @(posedge clock_i);
      check_val({cpu_hold, cpu_tri}, 8'h5a);
      check_val({3'h0, ref_tri}, 8'h1f);
      reg_write(8'h05, 8'h00);
      check_val({3'h0, ref_hold}, 8'h1f);
      pwr_down <= 1'b0;
      repeat (8) @(posedge clock_i);
      check_val({cpu_hold, cpu_tri}, 8'h00);
   end
   endtask
   // Foreign address gets no ack
   task t_wrong_addr;
      logic a0, a1;
   begin
      host.cond(1'b1, 1'b0);
      host.send_byte({ADDR ^ 7'h01, 1'b0}, a0);
      host.send_byte(8'h84, a1);
      host.cond(1'b0, 1'b1);
      check_val({6'h0, a0, a1}, 8'h03);
   end
   endtask
   // Watchdog
   initial
   begin
      repeat (60000) @(posedge clock_i);
      mismatches++;
      print_verdict;
   end
   // Main sequence
   initial
   begin
      {rst_n_i, pwr_down, low_phase, sel_b} = 4'h0;
      {pgood_n, sel_a, sel_c} = 3'h7;
      ref_sel = 5'h00;
      free_sel = 3'h0;
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i) pgood_n <= 1'b0;
      repeat (4) @(posedge clock_i);
      t_block_read;
      t_masks;
      t_test_modes;
      t_stop;
      t_power_down;
      t_wrong_addr;
      print_verdict;
   end
endmodule
